// ---- core/ebp_top.sv ----
/*
 * External bus cycle phaser: sequences address setup, command delay,
 * write setup/tristate, access and hold phases of one external cycle.
 * Assumes a classic Wishbone master on clk_i and an external memory that
 * holds read data valid until the read strobe rises.
 */
// Behaviour
// - Five phases run in fixed order; empty C, D and F are skipped
// - Phase lengths come from per-window config
// - Lengths count whole CPU clock periods
// - Setup 1-2, plus 0-3 on window change
// - Command delay 0-3, access 1-32 periods
// - Write setup or tristate 0-1 period
// - Hold keeps address and data 0-3
// - Read data latched as strobe ends
// - Early address change cannot corrupt read
// - Reference clock runs at CPU period when halved, twice it at full rate
// - CPU clock is master or half
`timescale 1ns/10ps
module ebp_top
  import ebp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Classic Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // External bus
  input  wire logic [EBP_DW-1:0] data_i,
  output logic      [EBP_AW-1:0] addr_o,
  output logic      [EBP_DW-1:0] data_o,
  output logic                   data_oe_o,
  output logic                   ale_o,
  output logic                   rd_n_o,
  output logic                   wr_n_o,
  output logic      [1:0]        cs_n_o,
  output logic                   upper_byte_enable_n_o,
  output logic                   reference_clock_output_o,
  output logic                   busy_o
);

  logic [EBP_CFG_W-1:0] cfg_ff [2];
  logic [1:0]           ctrl_ff;
  logic [EBP_AW-1:0]    addr_reg_ff;
  logic [EBP_DW-1:0]    wdata_ff;
  logic                 ack_ff;
  logic [31:0]          rd_mux;
  logic                 wb_req;
  logic                 start;
  logic                 start_wr;
  logic                 start_win;
  logic                 cpu_en;
  logic [EBP_DW-1:0]    din_s1_ff;
  logic [EBP_DW-1:0]    din_s2_ff;
  logic [EBP_DW-1:0]    rdata;
  logic                 cap;
  logic [2:0]           cap_dly_ff;
  logic                 pend_ff;

  ebp_phase_e           phase_ff;
  ebp_phase_e           nxt_phase;
  logic [5:0]           cnt_ff;
  logic [5:0]           nxt_cnt;
  logic                 wr_ff;
  logic                 win_ff;
  logic                 last_win_ff;
  logic                 win_valid_ff;
  ebp_cfg_s             cfg;
  ebp_pins_s            pins_ff;
  logic [5:0]           len_ab;
  logic [5:0]           len_c;
  logic [5:0]           len_d;
  logic [5:0]           len_e;
  logic [5:0]           len_f;
  logic                 win_chg;

  // Wishbone: one wait-state answer, ack lasts one cycle
  assign wb_req = cyc_i & stb_i & ~ack_ff;
  assign ack_o  = ack_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req;
    end
  end

  // Config writes, byte lane 0/1 gated; window config steers phases
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff[0]   <= EBP_CFG_RST;
      cfg_ff[1]   <= EBP_CFG_RST;
      ctrl_ff     <= 2'h0;
      addr_reg_ff <= '0;
      wdata_ff    <= '0;
    end else if (wb_req && we_i) begin
      case (adr_i)
        EBP_CFG0_OFS: begin
          if (sel_i[0]) cfg_ff[0][7:0] <= dat_i[7:0];
          if (sel_i[1]) cfg_ff[0][12:8] <= dat_i[12:8];
        end
        EBP_CFG1_OFS: begin
          if (sel_i[0]) cfg_ff[1][7:0] <= dat_i[7:0];
          if (sel_i[1]) cfg_ff[1][12:8] <= dat_i[12:8];
        end
        EBP_CTRL_OFS: begin
          if (sel_i[0]) ctrl_ff <= dat_i[1:0];
        end
        EBP_ADDR_OFS: begin
          if (sel_i[0]) addr_reg_ff[7:0] <= dat_i[7:0];
          if (sel_i[1]) addr_reg_ff[15:8] <= dat_i[15:8];
          if (sel_i[2]) addr_reg_ff[23:16] <= dat_i[23:16];
        end
        EBP_WDATA_OFS: begin
          if (sel_i[0]) wdata_ff[7:0] <= dat_i[7:0];
          if (sel_i[1]) wdata_ff[15:8] <= dat_i[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // Start command is ignored while a cycle is running
  assign start     = wb_req & we_i & sel_i[0] & (adr_i == EBP_CMD_OFS)
                     & (phase_ff == EBP_IDLE) & ~pend_ff;
  assign start_wr  = dat_i[EBP_CMD_WR_POS];
  assign start_win = dat_i[EBP_CMD_WIN_POS];

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (adr_i)
      EBP_CFG0_OFS:  rd_mux = {19'h0, cfg_ff[0]};
      EBP_CFG1_OFS:  rd_mux = {19'h0, cfg_ff[1]};
      EBP_CTRL_OFS:  rd_mux = {30'h0, ctrl_ff};
      EBP_ADDR_OFS:  rd_mux = {8'h00, addr_reg_ff};
      EBP_WDATA_OFS: rd_mux = {16'h0000, wdata_ff};
      EBP_STAT_OFS:  rd_mux = {9'h000, phase_ff, busy_o, rdata};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (wb_req && !we_i) begin
      dat_o <= rd_mux;
    end
  end

  // CPU rate enable and reference clock
  ebp_clk_en u_clk_en (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .cpu_clock_halving_select_i (ctrl_ff[EBP_CTRL_HALF_POS]),
    .cpu_en_o                   (cpu_en),
    .reference_clock_output_o   (reference_clock_output_o)
  );

  // Pin data enters through two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_s1_ff <= '0;
      din_s2_ff <= '0;
    end else begin
      din_s1_ff <= data_i;
      din_s2_ff <= din_s1_ff;
    end
  end

  // Strobe pin rises one clock after access ends and the sample needs two
  // synchroniser clocks more; capture waits so it takes the bus as it stood
  // on the strobe-rising edge, untouched by later address moves
  assign cap = cpu_en & (phase_ff == EBP_E) & ~wr_ff & (cnt_ff == 6'd1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_dly_ff <= 3'b000;
    end else begin
      cap_dly_ff <= {cap_dly_ff[1:0], cap};
    end
  end

  ebp_data_cap u_cap (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cap_i   (cap_dly_ff[2]),
    .din_i   (din_s2_ff),
    .rdata_o (rdata)
  );

  // Phase lengths of the active window, in CPU periods
  assign cfg     = ebp_cfg_s'(cfg_ff[win_ff]);
  assign win_chg = ~win_valid_ff | (last_win_ff != win_ff);
  assign len_ab  = 6'(cfg.ab2) + 6'd1
                   + (win_chg ? 6'(cfg.ext) : 6'd0);
  assign len_c   = 6'(cfg.cmd);
  assign len_d   = 6'(cfg.wsu);
  assign len_e   = 6'(cfg.acc) + 6'd1;
  assign len_f   = 6'(cfg.hld);

  // Phase sequencer; zero-length phases fall through at once
  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt   = cnt_ff;
    case (phase_ff)
      EBP_IDLE: begin
        nxt_phase = EBP_IDLE;
      end
      EBP_AB, EBP_C, EBP_D, EBP_E, EBP_F: begin
        if (cnt_ff > 6'd1) begin
          nxt_cnt = cnt_ff - 6'd1;
        end else begin
          // Fixed order, skipping empty phases
          nxt_phase = EBP_IDLE;
          nxt_cnt   = 6'd0;
          if (phase_ff == EBP_AB && len_c != 6'd0) begin
            nxt_phase = EBP_C;
            nxt_cnt   = len_c;
          end else if ((phase_ff == EBP_AB || phase_ff == EBP_C)
                       && len_d != 6'd0) begin
            nxt_phase = EBP_D;
            nxt_cnt   = len_d;
          end else if (phase_ff == EBP_AB || phase_ff == EBP_C
                       || phase_ff == EBP_D) begin
            nxt_phase = EBP_E;
            nxt_cnt   = len_e;
          end else if (phase_ff == EBP_E && len_f != 6'd0) begin
            nxt_phase = EBP_F;
            nxt_cnt   = len_f;
          end
        end
      end
      default: begin
        nxt_phase = EBP_IDLE;
        nxt_cnt   = 6'd0;
      end
    endcase
  end

  // Phase state advances only on CPU enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff <= EBP_IDLE;
      cnt_ff   <= 6'd0;
      wr_ff    <= 1'b0;
      win_ff   <= 1'b0;
    end else begin
      if (start) begin
        wr_ff  <= start_wr;
        win_ff <= start_win;
      end
      if (cpu_en) begin
        if (start || pend_ff) begin
          // Setup opens on a CPU edge, so its first period is whole
          phase_ff <= EBP_AB;
          cnt_ff   <= 6'd0;
        end else if (phase_ff == EBP_AB && cnt_ff == 6'd0) begin
          if (len_ab == 6'd1) begin
            phase_ff <= nxt_phase; // One-period setup ends now
            cnt_ff   <= nxt_cnt;
          end else begin
            cnt_ff <= len_ab - 6'd1; // First setup period done
          end
        end else begin
          phase_ff <= nxt_phase;
          cnt_ff   <= nxt_cnt;
        end
      end
    end
  end

  // Start seen between CPU edges waits here for the next one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= 1'b0;
    end else if (start && !cpu_en) begin
      pend_ff <= 1'b1;
    end else if (cpu_en) begin
      pend_ff <= 1'b0;
    end
  end

  // Remember window of last cycle for the change extension
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_win_ff  <= 1'b0;
      win_valid_ff <= 1'b0;
    end else if (cpu_en && phase_ff != EBP_IDLE && nxt_phase == EBP_IDLE
                 && !(phase_ff == EBP_AB && cnt_ff == 6'd0)) begin
      last_win_ff  <= win_ff;
      win_valid_ff <= 1'b1;
    end
  end

  // Pin drive, registered from phase state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_ff <= '{addr: '0, dout: '0, dout_oe: 1'b0, ale: 1'b0,
                   rd_n: 1'b1, wr_n: 1'b1, cs_n: 2'b11,
                   upper_byte_enable_n: 1'b1};
    end else begin
      pins_ff.addr    <= addr_reg_ff;
      pins_ff.cs_n    <= 2'b11;
      pins_ff.ale     <= 1'b0;
      pins_ff.rd_n    <= 1'b1;
      pins_ff.wr_n    <= 1'b1;
      pins_ff.dout_oe <= 1'b0;
      pins_ff.upper_byte_enable_n <= 1'b1;
      if (phase_ff != EBP_IDLE) begin
        pins_ff.cs_n[win_ff] <= 1'b0;
        pins_ff.upper_byte_enable_n <= 1'b0;
      end
      if (phase_ff == EBP_AB && ctrl_ff[EBP_CTRL_MUX_POS]) begin
        // Address on shared lines, latch strobe high
        pins_ff.dout    <= addr_reg_ff[EBP_DW-1:0];
        pins_ff.dout_oe <= 1'b1;
        pins_ff.ale     <= 1'b1;
      end else if (wr_ff && (phase_ff == EBP_D || phase_ff == EBP_E
                             || phase_ff == EBP_F)) begin
        // Write data held through hold phase
        pins_ff.dout    <= wdata_ff;
        pins_ff.dout_oe <= 1'b1;
      end
      if (phase_ff == EBP_E) begin
        pins_ff.rd_n <= wr_ff;
        pins_ff.wr_n <= ~wr_ff;
      end
    end
  end

  assign addr_o                = pins_ff.addr;
  assign data_o                = pins_ff.dout;
  assign data_oe_o             = pins_ff.dout_oe;
  assign ale_o                 = pins_ff.ale;
  assign rd_n_o                = pins_ff.rd_n;
  assign wr_n_o                = pins_ff.wr_n;
  assign cs_n_o                = pins_ff.cs_n;
  assign upper_byte_enable_n_o = pins_ff.upper_byte_enable_n;
  assign busy_o                = (phase_ff != EBP_IDLE);

endmodule

// ---- core/ebp_pkg.sv ----
/*
 * Shared constants and carrier types of the external bus cycle phaser.
 * Assumes a single CPU-side clock; included before every design module.
 */
package ebp_pkg;

  // Register map, byte offsets on a 32-bit classic Wishbone slave
  localparam logic [7:0] EBP_CFG0_OFS   = 8'h00; // Window 0 timing
  localparam logic [7:0] EBP_CFG1_OFS   = 8'h04; // Window 1 timing
  localparam logic [7:0] EBP_CTRL_OFS   = 8'h08; // Clock select, mux mode
  localparam logic [7:0] EBP_CMD_OFS    = 8'h0c; // Start a cycle
  localparam logic [7:0] EBP_ADDR_OFS   = 8'h10; // Address of next cycle
  localparam logic [7:0] EBP_WDATA_OFS  = 8'h14; // Write data
  localparam logic [7:0] EBP_STAT_OFS   = 8'h18; // Busy, phase, read data

  // Timing config field positions
  localparam int EBP_AB_POS   = 0;  // 1 bit: 0 -> 1 period, 1 -> 2
  localparam int EBP_EXT_POS  = 1;  // 2 bits: window change extension
  localparam int EBP_CMD_POS  = 3;  // 2 bits: command delay 0..3
  localparam int EBP_WSU_POS  = 5;  // 1 bit: write setup/tristate 0..1
  localparam int EBP_ACC_POS  = 6;  // 5 bits: access minus one, 1..32
  localparam int EBP_HLD_POS  = 11; // 2 bits: hold 0..3
  localparam int EBP_CFG_W    = 13;
  localparam logic [12:0] EBP_CFG_RST = 13'h0000;

  // Control register bits
  localparam int EBP_CTRL_HALF_POS = 0; // CPU clock = master / 2
  localparam int EBP_CTRL_MUX_POS  = 1; // Multiplexed bus
  localparam int EBP_CMD_WR_POS    = 0; // Start: 1 write, 0 read
  localparam int EBP_CMD_WIN_POS   = 1; // Start: window select

  // Bus widths
  localparam int EBP_AW = 24;
  localparam int EBP_DW = 16;

  // One-hot phase encoding
  typedef enum logic [5:0] {
    EBP_IDLE = 6'b000001,
    EBP_AB   = 6'b000010,
    EBP_C    = 6'b000100,
    EBP_D    = 6'b001000,
    EBP_E    = 6'b010000,
    EBP_F    = 6'b100000
  } ebp_phase_e;

  // Decoded per-window timing; members run MSB first, so hold leads
  typedef struct packed {
    logic [1:0] hld;
    logic [4:0] acc;
    logic       wsu;
    logic [1:0] cmd;
    logic [1:0] ext;
    logic       ab2;
  } ebp_cfg_s;

  // External bus pin bundle
  typedef struct packed {
    logic [EBP_AW-1:0] addr;
    logic [EBP_DW-1:0] dout;
    logic              dout_oe;
    logic              ale;
    logic              rd_n;
    logic              wr_n;
    logic [1:0]        cs_n;
    logic              upper_byte_enable_n;
  } ebp_pins_s;

endpackage

// ---- core/ebp_clk_en.sv ----
/*
 * CPU clock enable generator and reference clock output.
 * Assumes clk_i is the master clock; the CPU rate is a one-cycle enable.
 */
`timescale 1ns/10ps
module ebp_clk_en
  import ebp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cpu_clock_halving_select_i,
  output logic      cpu_en_o,
  output logic      reference_clock_output_o
);

  logic div_ff;
  logic ref_ff;

  // Divide toggle, only meaningful in halving mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 1'b0;
    end else begin
      div_ff <= ~div_ff;
    end
  end

  // Full rate: every cycle; halved: every second cycle
  assign cpu_en_o = cpu_clock_halving_select_i ? div_ff : 1'b1;

  // Reference clock toggles at CPU rate; at full rate it can only be
  // an approximation, so it toggles itself every clock, one period per two CPU periods
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_ff <= 1'b0;
    end else if (cpu_clock_halving_select_i) begin
      ref_ff <= div_ff; // One CPU period per high/low pair
    end else begin
      ref_ff <= ~ref_ff;
    end
  end

  assign reference_clock_output_o = ref_ff;

endmodule

// ---- core/ebp_data_cap.sv ----
/*
 * Read data capture register.
 * Assumes read data pins already pass a two-stage synchroniser upstream.
 */
`timescale 1ns/10ps
module ebp_data_cap
  import ebp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cap_i,
  input  wire logic [EBP_DW-1:0] din_i,
  output logic      [EBP_DW-1:0] rdata_o
);

  logic [EBP_DW-1:0] rdata_ff;

  // Latched only on the strobe-ending edge, not on address movement
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else if (cap_i) begin
      rdata_ff <= din_i;
    end
  end

  assign rdata_o = rdata_ff;

endmodule

// ---- testbench/ebp_assertions.sv ----
/* Checker of the phaser's Wishbone answer and external pin timing.
   Assumes it is bound to ebp_top and sees only its ports. */
`timescale 1ns/10ps
module ebp_assertions
  import ebp_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       data_oe_o,
  input wire logic       ale_o,
  input wire logic       rd_n_o,
  input wire logic       wr_n_o,
  input wire logic [1:0] cs_n_o,
  input wire logic       reference_clock_output_o,
  input wire logic       busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Strobe opens, then must close within 32 periods at half rate
  sequence s_rd_open; $fell(rd_n_o); endsequence
  sequence s_rd_shut; ##[1:64] rd_n_o; endsequence
  sequence s_wr_open; $fell(wr_n_o); endsequence
  sequence s_wr_shut; ##[1:64] wr_n_o; endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_strobe_excl: assert property (!(!rd_n_o && !wr_n_o))
    else $error("read and write strobes low together");
  // Pins lag the phase by one clock, so busy is checked one edge back
  a_strobe_cycle: assert property ((!rd_n_o || !wr_n_o) |->
    $past(busy_o) && cs_n_o != 2'b11)
    else $error("strobe outside a running cycle");
  a_read_len: assert property (s_rd_open |-> s_rd_shut)
    else $error("read access too long");
  a_write_len: assert property (s_wr_open |-> s_wr_shut)
    else $error("write access too long");
  a_ale_setup: assert property (ale_o |-> rd_n_o && wr_n_o)
    else $error("address latch strobe during access");
  a_read_float: assert property (!rd_n_o |-> !data_oe_o)
    else $error("data lines driven during read");
  a_refclk_runs: assert property (1 |-> ##[1:2]
    $changed(reference_clock_output_o))
    else $error("reference clock stalled");
endmodule

// ---- testbench/ebp_mem_model.sv ----
/* Behavioural external memory of sixteen words on the phaser's bus.
   Assumes registered strobes; mux_i tells it the bus mode. */
`timescale 1ns/10ps
module ebp_mem_model
  import ebp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              mux_i,
  input  wire logic [EBP_AW-1:0] addr_i,
  input  wire logic [EBP_DW-1:0] data_i,
  input  wire logic              ale_i,
  input  wire logic              rd_n_i,
  input  wire logic              wr_n_i,
  input  wire logic [1:0]        cs_n_i,
  output logic      [EBP_DW-1:0] data_o,
  output logic      [15:0]       lat_o
);
  logic [EBP_DW-1:0] mem [16];
  logic [EBP_DW-1:0] last;
  logic [3:0]        idx;
  assign idx = mux_i ? lat_o[3:0] : addr_i[3:0];
  // Address latch follows the shared lines while the strobe is high
  always @(posedge clk_i) if (ale_i) lat_o <= data_i;
  // Write data taken while the strobe is low; last sample wins
  always @(posedge clk_i) if (!wr_n_i && cs_n_i != 2'b11) mem[idx] <= data_i;
  // Released lines toggle so a stale value can never look valid
  always @(posedge clk_i) last <= data_o;
  assign data_o = (!rd_n_i && cs_n_i != 2'b11) ? mem[idx] : ~last;
endmodule

// ---- testbench/ebp_top_tb.sv ----
/* Self-checking bench of the phaser: Wishbone tasks, phase counts.
   Assumes ebp_mem_model as the far side and the checker bound below. */
`timescale 1ns/10ps
module ebp_top_tb;
  import ebp_pkg::*;
  logic              clk_i, rst_i, cyc, stb, we, mux, ack, busy;
  logic              oe, ale, rd_n, wr_n, ube_n, refclk;
  logic [7:0]        adr;
  logic [1:0]        cs_n;
  logic [15:0]       lat;
  logic [31:0]       wdat, rdat, q;
  logic [EBP_DW-1:0] din, dout;
  logic [EBP_AW-1:0] addr;
  int                error_cnt, checks_done, prev_win;
  logic [12:0]       cfgs [3] = '{13'h0000, 13'h0913, 13'h1fff};

  ebp_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .data_i(din), .addr_o(addr), .data_o(dout),
    .data_oe_o(oe), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .cs_n_o(cs_n), .upper_byte_enable_n_o(ube_n),
    .reference_clock_output_o(refclk), .busy_o(busy));
  ebp_mem_model mem (.clk_i(clk_i), .mux_i(mux), .addr_i(addr),
    .data_i(dout), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .cs_n_i(cs_n), .data_o(din), .lat_o(lat));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("mismatches %0d of %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Classic single cycle; waits for ack under a bounded count
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) check(32'h0, 32'h1);
  endtask

  // One external cycle; counts busy and strobe cycles at each edge
  task automatic run(input logic w, input logic win, input int per,
      input logic [12:0] c, input logic [15:0] d, input logic [23:0] a);
    int tot, acc, ext, n, ub, want;
    wb(1'b1, win ? EBP_CFG1_OFS : EBP_CFG0_OFS, {19'h0, c}, q);
    wb(1'b1, EBP_ADDR_OFS, {8'h0, a}, q);
    wb(1'b1, EBP_WDATA_OFS, {16'h0, d}, q);
    ext = (int'(win) != prev_win) ? int'(c[2:1]) : 0;
    prev_win = int'(win);
    wb(1'b1, EBP_CMD_OFS, {30'h0, win, w}, q);
    want = per * (2 + c[0] + ext + c[4:3] + c[5] + c[10:6] + c[12:11]);
    // The bus task's last edge is the first at which busy can show
    tot = int'(busy === 1'b1);
    acc = 0;
    ub = 0;
    n = 0;
    while (n < 300 && !(tot > 0 && busy !== 1'b1 && rd_n === 1'b1 &&
           wr_n === 1'b1)) begin
      @(posedge clk_i);
      n++;
      if (busy === 1'b1) tot++;
      if (rd_n === 1'b0 || wr_n === 1'b0) acc++;
      if (ube_n === 1'b0) ub++;
    end
    check(32'(tot), 32'(want));
    check(32'(ub), 32'(want));
    check(32'(acc), 32'(per * (c[10:6] + 1)));
    if (!w) begin
      wb(1'b0, EBP_STAT_OFS, 32'h0, q);
      check({16'h0, q[15:0]}, {16'h0, d});
    end
  endtask

  // Reset values of config, control and status
  task automatic t_reset;
    wb(1'b0, EBP_CFG0_OFS, 32'h0, q);
    check(q, {19'h0, EBP_CFG_RST});
    wb(1'b0, EBP_CTRL_OFS, 32'h0, q);
    check(q, 32'h0);
    wb(1'b0, EBP_STAT_OFS, 32'h0, q);
    check(q, {9'h0, EBP_IDLE, 17'h0});
  endtask

  // Minimum, mixed and maximum phase lengths, windows alternating
  task automatic t_phases;
    for (int i = 0; i < 3; i++) begin
      run(1'b1, i[0], 1, cfgs[i], 16'h5a30 + 16'(i), 24'h0a0000 + 24'(i));
      run(1'b0, i[0], 1, cfgs[i], 16'h5a30 + 16'(i), 24'h0a0000 + 24'(i));
    end
  endtask

  // Halved CPU clock doubles every count
  task automatic t_half;
    wb(1'b1, EBP_CTRL_OFS, 32'h1, q);
    run(1'b1, 1'b1, 2, 13'h0913, 16'hc3e1, 24'h000105);
    run(1'b0, 1'b1, 2, 13'h0913, 16'hc3e1, 24'h000105);
    wb(1'b1, EBP_CTRL_OFS, 32'h0, q);
  endtask

  // Multiplexed bus: address latched from the shared lines
  task automatic t_mux;
    mux <= 1'b1;
    wb(1'b1, EBP_CTRL_OFS, 32'h2, q);
    run(1'b1, 1'b0, 1, 13'h0021, 16'h9e07, 24'h3c4d07);
    check({16'h0, lat}, 32'h00004d07);
    run(1'b0, 1'b0, 1, 13'h0021, 16'h9e07, 24'h3c4d07);
    wb(1'b1, EBP_CTRL_OFS, 32'h0, q);
    mux <= 1'b0;
  endtask

  // Unmapped place: write ignored, read gives zero
  task automatic t_unmapped;
    wb(1'b1, 8'h1c, 32'hffffffff, q);
    wb(1'b0, 8'h1c, 32'h0, q);
    check(q, 32'h0);
  endtask

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; mux = 1'b0;
    adr = 8'h00; wdat = 32'h0; error_cnt = 0; checks_done = 0;
    prev_win = -1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_phases;
    t_half;
    t_mux;
    t_unmapped;
    print_verdict;
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #3000000;
    error_cnt++;
    print_verdict;
  end
endmodule

bind ebp_top ebp_assertions chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .data_oe_o(data_oe_o),
  .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .cs_n_o(cs_n_o),
  .reference_clock_output_o(reference_clock_output_o), .busy_o(busy_o));
